// >>> rtl/pdc_cfg_if.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// configuration pins between controller and synthesizer
// ****************************************
interface pdc_cfg_if;
    import pdc_pkg::*;
    logic p_load_n;
    logic [M_W-1:0] m;
    logic [N_W-1:0] n;
    logic s_clock;
    logic s_data;
    logic s_load;

    modport dev (
        input p_load_n,
        input m,
        input n,
        input s_clock,
        input s_data,
        input s_load
    );

    modport host (
        output p_load_n,
        output m,
        output n,
        output s_clock,
        output s_data,
        output s_load
    );
endinterface
`default_nettype wire

// >>> rtl/pdc_dev.sv
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// R1: output frequency is crystal/16 times M over N
// R2: controller keeps M within 200 to 400; pdc_host passes cfg_m_i on unchecked
// R3: divider select codes give 1, 2, 4, 8
// R4: parallel strobe rising edge captures M and N
// R5: strobe low makes divisor latches transparent
// R6: serial clock samples data into 14-bit register
// R7: serial load works only with strobe high
// R8: stream order: monitor, then N, then M
// R9: each field shifted most significant bit first
// R10: serial strobe falling edge transfers shifted values
// R11: monitor select set only by serial stream
// R12: strobe low forces monitor select to 000
// R13: controller loads parallel at power-up, serial later
// R14: shift register advances on serial clock rise
// R15: parallel interface wins over serial interface
// R16: monitor code 110 selects bypass through dividers
// R17: latched values hold until next load event
// R18: overlong stream keeps only last 14 bits
module pdc_dev
    import pdc_pkg::*;
(
    // clock, reset, enable
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    // configuration pins
    pdc_cfg_if.dev cfg,
    // reference
    input wire logic [FREQ_W-1:0] crystal_frequency_i,
    // active configuration
    output logic [M_W-1:0] loop_div_o,
    output logic [N_W-1:0] out_div_sel_o,
    output logic [3:0] out_ratio_o,
    output logic [T_W-1:0] mon_sel_o,
    output logic bypass_o,
    output logic [FOUT_W-1:0] fout_freq_o,
    // clock outputs in bypass, monitor pin
    output logic synth_out_o,
    output logic monitor_o
);

    // ****************************************
    // pin edge detection
    // ****************************************
    // pins are synchronous to core_clk_i, so a single delay stage suffices
    logic s_clock_d_r;
    logic s_load_d_r;
    logic s_clock_rise;
    logic s_load_fall;

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s_clock_d_r <= 1'b0;
            s_load_d_r <= 1'b0;
        end else if (ce_i) begin
            s_clock_d_r <= cfg.s_clock;
            s_load_d_r <= cfg.s_load;
        end
    end

    assign s_clock_rise = cfg.s_clock && !s_clock_d_r;
    assign s_load_fall = !cfg.s_load && s_load_d_r;

    // ****************************************
    // serial shift register
    // ****************************************
    logic [SR_W-1:0] shift_r;

    // oldest bits fall off the top, last 14 stay (see R18)
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            shift_r <= '0;
        end else if (ce_i && s_clock_rise) begin // see R14
            shift_r <= {shift_r[SR_W-2:0], cfg.s_data}; // see R6
        end
    end

    // ****************************************
    // divisor latches
    // ****************************************
    logic [M_W-1:0] m_r;
    logic [N_W-1:0] n_r;
    logic [T_W-1:0] t_r;
    logic ser_load;

    // strobe must be high for the serial latch to act (see R7)
    assign ser_load = s_load_fall && cfg.p_load_n;

    // the last transparent sample is what the rising strobe captures
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            m_r <= M_RST;
            n_r <= N_RST;
        end else if (ce_i) begin
            if (!cfg.p_load_n) begin // see R15
                m_r <= cfg.m; // see R5 R4
                n_r <= cfg.n; // see R5 R4
            end else if (ser_load) begin
                m_r <= shift_r[SR_M_LSB +: M_W]; // see R8 R9 R10
                n_r <= shift_r[SR_N_LSB +: N_W]; // see R8 R9 R10
            end
        end
    end // see R17

    // no parallel pins reach the monitor select (see R11)
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            t_r <= T_RST;
        end else if (ce_i) begin
            if (!cfg.p_load_n) begin
                t_r <= T_RST; // see R12
            end else if (ser_load) begin
                t_r <= shift_r[SR_T_LSB +: T_W]; // see R8 R10
            end
        end
    end

    // ****************************************
    // frequency and status
    // ****************************************
    logic [FOUT_W-1:0] fout_r;

    // a divisor outside M_MIN..M_MAX is not refused: lock is the controller's job
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            fout_r <= '0;
        end else if (ce_i) begin
            fout_r <= fout_of(crystal_frequency_i, m_r, n_r); // see R1 R3
        end
    end

    assign loop_div_o = m_r;
    assign out_div_sel_o = n_r;
    assign out_ratio_o = out_ratio(n_r); // see R3
    assign mon_sel_o = t_r;
    assign bypass_o = (t_r == T_BYPASS);
    assign fout_freq_o = fout_r;

    // ****************************************
    // bypass dividers on the serial clock
    // ****************************************
    logic [2:0] n_cnt_r;
    logic n_tog_r;
    logic [M_W-1:0] m_cnt_r;
    logic m_pulse_r;
    logic [2:0] n_half;

    assign n_half = 3'(out_ratio(n_r) >> 1) - 3'h1;

    // divide by 1 follows the pin; others toggle every ratio/2 rising edges
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            n_cnt_r <= '0;
            n_tog_r <= 1'b0;
        end else if (ce_i) begin
            if (!bypass_o) begin
                n_cnt_r <= '0;
                n_tog_r <= 1'b0;
            end else if (s_clock_rise) begin // see R16
                if (n_cnt_r == n_half) begin
                    n_cnt_r <= '0;
                    n_tog_r <= !n_tog_r;
                end else begin
                    n_cnt_r <= n_cnt_r + 3'h1;
                end
            end
        end
    end

    // loop counter gives one high serial-clock period per M edges, not 50% duty
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            m_cnt_r <= '0;
            m_pulse_r <= 1'b0;
        end else if (ce_i) begin
            if (!bypass_o) begin
                m_cnt_r <= '0;
                m_pulse_r <= 1'b0;
            end else if (s_clock_rise) begin // see R16
                if (m_cnt_r >= m_r - 9'h001) begin
                    m_cnt_r <= '0;
                    m_pulse_r <= 1'b1;
                end else begin
                    m_cnt_r <= m_cnt_r + 9'h001;
                    m_pulse_r <= 1'b0;
                end
            end
        end
    end

    // ****************************************
    // output pins
    // ****************************************
    logic synth_r;
    logic mon_r;
    logic mon_nxt;

    // analog nodes (reference, vco) are not modelled and read low
    always_comb begin
        unique case (t_r)
            T_SHIFT_OUT: mon_nxt = shift_r[SR_W-1];
            T_HIGH: mon_nxt = 1'b1;
            T_BYPASS: mon_nxt = m_pulse_r; // see R16
            default: mon_nxt = 1'b0;
        endcase
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            synth_r <= 1'b0;
            mon_r <= 1'b0;
        end else if (ce_i) begin
            mon_r <= mon_nxt;
            if (!bypass_o) begin
                synth_r <= 1'b0;
            end else if (n_r == 2'h0) begin
                synth_r <= cfg.s_clock; // see R16
            end else begin
                synth_r <= n_tog_r ^ (s_clock_rise && n_cnt_r == n_half);
            end
        end
    end

    assign synth_out_o = synth_r;
    assign monitor_o = mon_r;

endmodule // pdc_dev
`default_nettype wire

// >>> rtl/pdc_host.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// controller end: drives parallel and serial loads
// ****************************************
module pdc_host
    import pdc_pkg::*;
(
    // clock, reset, enable
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    // user commands
    input wire logic par_req_i,
    input wire logic ser_req_i,
    input wire logic [M_W-1:0] cfg_m_i,
    input wire logic [N_W-1:0] cfg_n_i,
    input wire logic [T_W-1:0] cfg_t_i,
    output logic busy_o,
    output logic done_o,
    // pins
    pdc_cfg_if.host cfg
);

    typedef enum logic [2:0] {
        ST_IDLE, ST_P_LOW, ST_P_HOLD, ST_S_LO, ST_S_HI, ST_L_SETUP, ST_L_HI
    } pdc_hst_e;

    pdc_hst_e state_r;
    logic [TMR_W-1:0] tmr_r;
    logic [SR_W-1:0] word_r;
    logic [3:0] bits_r;
    logic p_load_n_r;
    logic [M_W-1:0] m_r;
    logic [N_W-1:0] n_r;
    logic s_clock_r;
    logic s_load_r;
    logic done_r;
    logic tmr_done;

    assign tmr_done = (tmr_r == '0);
    assign busy_o = (state_r != ST_IDLE);
    assign done_o = done_r;
    assign cfg.p_load_n = p_load_n_r;
    assign cfg.m = m_r;
    assign cfg.n = n_r;
    assign cfg.s_clock = s_clock_r;
    assign cfg.s_data = word_r[SR_W-1];
    assign cfg.s_load = s_load_r;

    // ****************************************
    // sequencer
    // ****************************************
    // strobe held low from reset: power-up load goes through the parallel port (see R13)
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_r <= ST_IDLE;
            tmr_r <= '0;
            word_r <= '0;
            bits_r <= '0;
            p_load_n_r <= 1'b0;
            m_r <= M_RST;
            n_r <= N_RST;
            s_clock_r <= 1'b0;
            s_load_r <= 1'b0;
            done_r <= 1'b0;
        end else if (ce_i) begin
            done_r <= 1'b0;
            if (!tmr_done) begin
                tmr_r <= tmr_r - 1'b1;
            end
            unique case (state_r)
                ST_IDLE: begin
                    if (par_req_i) begin
                        m_r <= cfg_m_i;
                        n_r <= cfg_n_i;
                        p_load_n_r <= 1'b0;
                        tmr_r <= TMR_W'(PW_CYC - 1);
                        state_r <= ST_P_LOW;
                    end else if (ser_req_i && p_load_n_r) begin // see R7
                        word_r <= {cfg_t_i, cfg_n_i, cfg_m_i}; // see R8 R9
                        bits_r <= 4'(SR_W);
                        tmr_r <= TMR_W'(SCLK_HALF_CYC - 1);
                        state_r <= ST_S_LO;
                    end
                end
                ST_P_LOW: begin
                    if (tmr_done) begin
                        p_load_n_r <= 1'b1;
                        tmr_r <= TMR_W'(HOLD_CYC - 1);
                        state_r <= ST_P_HOLD;
                    end
                end
                ST_P_HOLD: begin
                    if (tmr_done) begin
                        done_r <= 1'b1;
                        state_r <= ST_IDLE;
                    end
                end
                ST_S_LO: begin
                    if (tmr_done) begin
                        s_clock_r <= 1'b1;
                        tmr_r <= TMR_W'(SCLK_HALF_CYC - 1);
                        state_r <= ST_S_HI;
                    end
                end
                ST_S_HI: begin
                    if (tmr_done) begin
                        s_clock_r <= 1'b0;
                        word_r <= {word_r[SR_W-2:0], 1'b0};
                        bits_r <= bits_r - 1'b1;
                        if (bits_r == 4'h1) begin
                            tmr_r <= TMR_W'(SETUP_CYC - 1);
                            state_r <= ST_L_SETUP;
                        end else begin
                            tmr_r <= TMR_W'(SCLK_HALF_CYC - 1);
                            state_r <= ST_S_LO;
                        end
                    end
                end
                ST_L_SETUP: begin
                    if (tmr_done) begin
                        s_load_r <= 1'b1;
                        tmr_r <= TMR_W'(PW_CYC - 1);
                        state_r <= ST_L_HI;
                    end
                end
                ST_L_HI: begin
                    // falling edge here latches the word (see R10)
                    if (tmr_done) begin
                        s_load_r <= 1'b0;
                        done_r <= 1'b1;
                        state_r <= ST_IDLE;
                    end
                end
            endcase
        end
    end

endmodule // pdc_host
`default_nettype wire

// >>> rtl/pdc_pkg.sv
`default_nettype none
// ****************************************
// configuration loader constants
// ****************************************
package pdc_pkg;

    // field widths
    localparam int M_W = 9;
    localparam int N_W = 2;
    localparam int T_W = 3;
    localparam int SR_W = T_W + N_W + M_W;

    // positions inside the 14-bit shift word, first bit shifted ends on top
    localparam int SR_M_LSB = 0;
    localparam int SR_N_LSB = SR_M_LSB + M_W;
    localparam int SR_T_LSB = SR_N_LSB + N_W;

    // reset values: the divisor pins have pull-ups, so an idle board reads ones
    localparam logic [M_W-1:0] M_RST = 9'h1FF;
    localparam logic [N_W-1:0] N_RST = 2'h3;
    localparam logic [T_W-1:0] T_RST = 3'h0;

    // reference pre-divider is 16, i.e. a shift of 4
    localparam int REF_DIV_SHIFT = 4;

    // monitor-select codes
    localparam logic [T_W-1:0] T_SHIFT_OUT = 3'h0;
    localparam logic [T_W-1:0] T_HIGH = 3'h1;
    localparam logic [T_W-1:0] T_MCOUNT = 3'h3;
    localparam logic [T_W-1:0] T_LOW = 3'h5;
    localparam logic [T_W-1:0] T_BYPASS = 3'h6;

    // suggested loop divisor window for a 16 MHz reference
    localparam logic [M_W-1:0] M_MIN = 9'h0C8;
    localparam logic [M_W-1:0] M_MAX = 9'h190;

    // timing, figures in ns, counts derived at 250 MHz
    localparam int CLK_PERIOD_NS = 4;
    localparam int T_SETUP_NS = 20;
    localparam int T_HOLD_NS = 20;
    localparam int T_PW_NS = 50;
    localparam int T_SCLK_HALF_NS = 50;
    localparam int SETUP_CYC = (T_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int HOLD_CYC = (T_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PW_CYC = (T_PW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SCLK_HALF_CYC = (T_SCLK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TMR_W = 8;

    localparam int FREQ_W = 32;
    localparam int FOUT_W = FREQ_W + M_W;

    // output divider ratio for a select code: 1, 2, 4, 8
    function automatic logic [3:0] out_ratio(input logic [N_W-1:0] sel);
        out_ratio = 4'h1 << sel;
    endfunction

    // synthesized frequency: crystal / 16 * M / N, N a power of two
    function automatic logic [FOUT_W-1:0] fout_of(input logic [FREQ_W-1:0] xtal,
                                                  input logic [M_W-1:0] m,
                                                  input logic [N_W-1:0] n);
        logic [FOUT_W-1:0] prod;
        prod = FOUT_W'(xtal) * FOUT_W'(m);
        fout_of = prod >> (REF_DIV_SHIFT + int'(n));
    endfunction

endpackage
`default_nettype wire

// >>> test/pdc_chk.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// checker on the configuration pins and device outputs
// ****************************************
module pdc_chk
    import pdc_pkg::*;
(
    // clock, reset
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    // configuration pins
    input wire logic p_load_n,
    input wire logic [M_W-1:0] m,
    input wire logic [N_W-1:0] n,
    input wire logic s_clock,
    input wire logic s_data,
    input wire logic s_load,
    // device side
    input wire logic [FREQ_W-1:0] crystal_frequency_i,
    input wire logic [M_W-1:0] loop_div_o,
    input wire logic [N_W-1:0] out_div_sel_o,
    input wire logic [3:0] out_ratio_o,
    input wire logic [T_W-1:0] mon_sel_o,
    input wire logic bypass_o,
    input wire logic [FOUT_W-1:0] fout_freq_o,
    input wire logic synth_out_o
);
    logic sclk_r;
    logic [SR_W-1:0] sh_r;

    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rst_n_i);

    // ****************************************
    // own copy of the shift word
    // ****************************************
    // ce is not watched: the bench keeps it high
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sclk_r <= 1'b0;
        end else begin
            sclk_r <= s_clock;
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sh_r <= '0;
        end else if (s_clock && !sclk_r) begin
            sh_r <= {sh_r[SR_W-2:0], s_data};
        end
    end

    // ****************************************
    // load steps
    // ****************************************
    sequence par_open_s;
        !p_load_n;
    endsequence

    sequence ser_latch_s;
        p_load_n && $fell(s_load);
    endsequence

    sequence par_clash_s;
        !p_load_n && $fell(s_load);
    endsequence

    sequence ser_active_s;
        s_clock || s_load;
    endsequence

    par_capture_a: assert property (par_open_s |=>
        loop_div_o == $past(m) && out_div_sel_o == $past(n)) else $error("parallel capture wrong");
    mon_forced_a: assert property (par_open_s |=> mon_sel_o == 3'h0)
        else $error("monitor select not forced");
    ser_latch_a: assert property (ser_latch_s |=>
        {mon_sel_o, out_div_sel_o, loop_div_o} == $past(sh_r)) else $error("serial latch wrong");
    par_wins_a: assert property (par_clash_s |=> mon_sel_o == 3'h0 && loop_div_o == $past(m))
        else $error("serial latch not refused");
    cfg_hold_a: assert property (p_load_n && !$fell(s_load) |=>
        $stable(loop_div_o) && $stable(out_div_sel_o) && $stable(mon_sel_o)) else $error("config moved");
    ratio_map_a: assert property (out_ratio_o == (4'h1 << out_div_sel_o))
        else $error("divider ratio wrong");
    bypass_code_a: assert property (bypass_o == (mon_sel_o == 3'h6))
        else $error("bypass flag wrong");
    fout_calc_a: assert property (1'b1 |=> fout_freq_o ==
        ((FOUT_W'($past(crystal_frequency_i)) * FOUT_W'($past(loop_div_o))) >> (4 + $past(out_div_sel_o))))
        else $error("frequency result wrong");
    synth_quiet_a: assert property (!bypass_o && !$past(bypass_o) |-> !synth_out_o)
        else $error("output clock outside bypass");
    ser_strobe_a: assert property (ser_active_s |-> p_load_n)
        else $error("serial pins moved with parallel strobe low");
endmodule // pdc_chk
`default_nettype wire

// >>> test/tb.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// bench: controller end drives device end
// ****************************************
module tb;
    import pdc_pkg::*;
    typedef struct {
        logic [M_W-1:0] m;
        logic [N_W-1:0] n;
        logic [T_W-1:0] t;
        logic [FREQ_W-1:0] x;
    } pdc_exp_s;

    logic core_clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic ce_i = 1'b1;
    logic par_req_i = 1'b0;
    logic ser_req_i = 1'b0;
    logic [M_W-1:0] cfg_m_i = 9'h000;
    logic [N_W-1:0] cfg_n_i = 2'h0;
    logic [T_W-1:0] cfg_t_i = 3'h0;
    logic [FREQ_W-1:0] crystal_r = 32'h00F42400;
    logic busy_o;
    logic done_o;
    logic [M_W-1:0] loop_div_o;
    logic [N_W-1:0] out_div_sel_o;
    logic [3:0] out_ratio_o;
    logic [T_W-1:0] mon_sel_o;
    logic bypass_o;
    logic [FOUT_W-1:0] fout_freq_o;
    logic synth_out_o;
    logic monitor_o;
    int n_errors = 0;
    int checks_done = 0;
    int n_synth = 0;
    int n_mon = 0;
    pdc_exp_s exp_q[$];

    always #2 core_clk_i = ~core_clk_i;
    always @(posedge synth_out_o) n_synth++;
    always @(posedge monitor_o) n_mon++;

    pdc_cfg_if pdc_cfg_if_i();
    pdc_host pdc_host_i (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i), .par_req_i(par_req_i),
        .ser_req_i(ser_req_i), .cfg_m_i(cfg_m_i), .cfg_n_i(cfg_n_i), .cfg_t_i(cfg_t_i), .busy_o(busy_o),
        .done_o(done_o), .cfg(pdc_cfg_if_i));
    pdc_dev pdc_dev_i (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i), .cfg(pdc_cfg_if_i),
        .crystal_frequency_i(crystal_r), .loop_div_o(loop_div_o), .out_div_sel_o(out_div_sel_o),
        .out_ratio_o(out_ratio_o), .mon_sel_o(mon_sel_o), .bypass_o(bypass_o), .fout_freq_o(fout_freq_o),
        .synth_out_o(synth_out_o), .monitor_o(monitor_o));
    pdc_chk pdc_chk_i (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .p_load_n(pdc_cfg_if_i.p_load_n),
        .m(pdc_cfg_if_i.m), .n(pdc_cfg_if_i.n), .s_clock(pdc_cfg_if_i.s_clock), .s_data(pdc_cfg_if_i.s_data),
        .s_load(pdc_cfg_if_i.s_load), .crystal_frequency_i(crystal_r), .loop_div_o(loop_div_o),
        .out_div_sel_o(out_div_sel_o), .out_ratio_o(out_ratio_o), .mon_sel_o(mon_sel_o), .bypass_o(bypass_o),
        .fout_freq_o(fout_freq_o), .synth_out_o(synth_out_o));

    // ****************************************
    // compare and close
    // ****************************************
    task automatic chk(input logic [47:0] seen, input logic [47:0] want);
        checks_done++;
        if (seen !== want) begin
            n_errors++;
            $display("unexpected at %0t: seen %0h expected %0h", $time, seen, want);
        end
    endtask

    task automatic finish_test();
        $display("comparisons %0d, mismatches %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // ****************************************
    // drivers
    // ****************************************
    // bounded; the pause after done lets the monitor compare before inputs move
    task automatic wait_done();
        int i;
        for (i = 0; i < 1000 && done_o !== 1'b1; i++) begin
            @(negedge core_clk_i);
        end
        if (done_o !== 1'b1) begin
            n_errors++;
            finish_test();
        end
        repeat (6) @(negedge core_clk_i);
    endtask

    task automatic do_load(input logic ser, input logic [M_W-1:0] mv, input logic [N_W-1:0] nv,
                           input logic [T_W-1:0] tv, input logic intrude);
        pdc_exp_s e;
        e.m = mv;
        e.n = nv;
        e.t = ser ? tv : 3'h0;
        e.x = $urandom();
        exp_q.push_back(e);
        @(posedge core_clk_i);
        crystal_r <= e.x;
        cfg_m_i <= mv;
        cfg_n_i <= nv;
        cfg_t_i <= tv;
        par_req_i <= !ser;
        ser_req_i <= ser;
        @(posedge core_clk_i);
        par_req_i <= intrude;
        ser_req_i <= 1'b0;
        @(posedge core_clk_i);
        par_req_i <= 1'b0;
        wait_done();
    endtask

    // ****************************************
    // monitor: one note per finished load
    // ****************************************
    always @(negedge core_clk_i) begin : mon_blk
        pdc_exp_s e;
        if (done_o === 1'b1) begin
            repeat (3) @(negedge core_clk_i);
            if (exp_q.size() == 0) begin
                chk(48'h1, 48'h0);
            end else begin
                e = exp_q.pop_front();
                chk(48'(loop_div_o), 48'(e.m));
                chk(48'(out_div_sel_o), 48'(e.n));
                chk(48'(mon_sel_o), 48'(e.t));
                chk(48'(out_ratio_o), 48'(4'h1 << e.n));
                chk(48'(fout_freq_o), (48'(e.x) * 48'(e.m)) >> (4 + e.n));
                chk(48'(bypass_o), 48'(e.t == 3'h6));
                if (e.t inside {3'h1, 3'h2, 3'h4, 3'h5, 3'h7}) begin
                    chk(48'(monitor_o), 48'(e.t == 3'h1));
                end
            end
        end
    end

    // ****************************************
    // main sequence
    // ****************************************
    initial begin : main_blk
        int i;
        void'($urandom(32'h6C64E2AE));
        repeat (10) @(posedge core_clk_i);
        rst_n_i <= 1'b1;
        @(negedge core_clk_i);
        chk(48'(loop_div_o), 48'h1FF);
        chk(48'(mon_sel_o), 48'h0);
        @(posedge core_clk_i);
        ser_req_i <= 1'b1;
        @(posedge core_clk_i);
        ser_req_i <= 1'b0;
        repeat (30) @(negedge core_clk_i);
        chk(48'(busy_o), 48'h0);
        $display("test reset_and_early_serial done");
        for (i = 0; i < 4; i++) begin
            do_load(1'b0, 9'(200 + $urandom_range(200)), 2'(i), 3'h0, 1'b0);
        end
        $display("test parallel_codes done");
        for (i = 0; i < 8; i++) begin
            do_load(1'b1, 9'($urandom()), 2'($urandom()), 3'(i), 1'b0);
        end
        $display("test serial_codes done");
        // a parallel request while busy must be dropped, bypass must keep the serial result
        do_load(1'b1, 9'h004, 2'h1, 3'h6, 1'b0);
        n_synth = 0;
        n_mon = 0;
        do_load(1'b1, 9'h004, 2'h1, 3'h6, 1'b1);
        // fourteen serial clocks: divide by 2 gives 7 cycles, loop counter 4 gives 3 pulses
        chk(48'(n_synth), 48'(SR_W / 2));
        chk(48'(n_mon), 48'(SR_W / 4));
        $display("test bypass_and_busy done");
        do_load(1'b0, 9'h106, 2'h1, 3'h0, 1'b0);
        $display("test parallel_after_serial done");
        finish_test();
    end
endmodule // tb
`default_nettype wire
